// [inc/jisc_consts.vh]
// Constants for the scan port: addresses, codes, chain layout, buffer shape
`ifndef JISC_CONSTS_VH
`define JISC_CONSTS_VH
`define JISC_IR_ADDR 32'h04000200
`define JISC_IR_RESET 16'hFFFF
`define JISC_IR_LOW_ONES 12'hFFF
`define JISC_IR_CAPTURE_LOW 2'h1
`define JISC_IR_W 16
`define JISC_FLD_W 4
`define JISC_OP_EXTEST 4'h0
`define JISC_OP_WAKE 4'h1
`define JISC_OP_SAMPLE 4'h4
`define JISC_OP_DRST_OFF 4'h6
`define JISC_OP_DRST_ON 4'h7
`define JISC_OP_IRQ_HI 3'h5
`define JISC_OP_BYPASS 4'hF
`define JISC_BSC_LEN 339
`define JISC_D_IN_LSB 307
`define JISC_D_OUT_LSB 267
`define JISC_D_CTL_LSB 235
`define JISC_A_OUT_MSB 224
`define JISC_A_CTL_MSB 182
`define JISC_A25_CTL 157
`define JISC_D_W 32
`define JISC_A_W 26
`define JISC_FIFO_DEPTH 32
`define JISC_FIFO_AW 5
`endif

// [rtl/jisc_fifo.v]
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module jisc_fifo #(
    parameter W = 4,
    parameter D = 32,
    parameter AW = 5
) (
    input wire mclk,
    input wire rst_b,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != D[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/jisc_tap_fsm.v]
// Test access port state machine, advanced on each sampled rising link clock
`timescale 1ns/1ps
`default_nettype none
module jisc_tap_fsm (
    input wire mclk,
    input wire rst_b,
    input wire trst_s_b,
    input wire tck_rise,
    input wire tms_s,
    output wire in_tlr,
    output wire cap_dr,
    output wire sh_dr,
    output wire up_dr,
    output wire cap_ir,
    output wire sh_ir,
    output wire up_ir
);
    localparam TLR = 16'h0001;
    localparam RTI = 16'h0002;
    localparam SELDR = 16'h0004;
    localparam CAPDR = 16'h0008;
    localparam SHDR = 16'h0010;
    localparam EX1DR = 16'h0020;
    localparam PDR = 16'h0040;
    localparam EX2DR = 16'h0080;
    localparam UPDR = 16'h0100;
    localparam SELIR = 16'h0200;
    localparam CAPIR = 16'h0400;
    localparam SHIR = 16'h0800;
    localparam EX1IR = 16'h1000;
    localparam PIR = 16'h2000;
    localparam EX2IR = 16'h4000;
    localparam UPIR = 16'h8000;

    reg [15:0] state;
    reg [15:0] next_state;

    always @* begin
        case (state)
            TLR: next_state = tms_s ? TLR : RTI;
            RTI: next_state = tms_s ? SELDR : RTI;
            SELDR: next_state = tms_s ? SELIR : CAPDR;
            CAPDR: next_state = tms_s ? EX1DR : SHDR;
            SHDR: next_state = tms_s ? EX1DR : SHDR;
            EX1DR: next_state = tms_s ? UPDR : PDR;
            PDR: next_state = tms_s ? EX2DR : PDR;
            EX2DR: next_state = tms_s ? UPDR : SHDR;
            UPDR: next_state = tms_s ? SELDR : RTI;
            SELIR: next_state = tms_s ? TLR : CAPIR;
            CAPIR: next_state = tms_s ? EX1IR : SHIR;
            SHIR: next_state = tms_s ? EX1IR : SHIR;
            EX1IR: next_state = tms_s ? UPIR : PIR;
            PIR: next_state = tms_s ? EX2IR : PIR;
            EX2IR: next_state = tms_s ? UPIR : SHIR;
            UPIR: next_state = tms_s ? SELDR : RTI;
            default: next_state = TLR;
        endcase
    end

    // Reset pin forces the idle reset state with no link clock edge
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= TLR;
        end else if (!trst_s_b) begin
            state <= TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    assign in_tlr = state[0];
    assign cap_dr = state[3];
    assign sh_dr = state[4];
    assign up_dr = state[8];
    assign cap_ir = state[10];
    assign sh_ir = state[11];
    assign up_ir = state[15];
endmodule
`default_nettype wire

// [rtl/jisc_scan_port.v]
// Debug/test scan port: instruction holder, bypass cell, pin scan chain
// Functional notes
// - A one-bit bypass cell exists that the CPU cannot reach.
// - Under the bypass command the serial path runs through the bypass cell.
// - The 16-bit instruction holder is CPU-readable only, at 0x04000200.
// - Reset pin low or the idle reset state sets the instruction holder to all ones.
// - Only the serial port loads bits 15 to 12; CPU writes do nothing.
// - Bits 11 to 0 of the instruction holder always read as ones.
// - Field value 1111 is the bypass command and the reset value.
// - 0110 negates and 0111 asserts debug reset, 101x interrupts, 0001 wakes.
// - The pin scan chain is a serial shift chain of pad cells.
// - Boundary test and sample commands select the chain with capture and update.
// - Cell 338 is nearest TDI; A0-A25 outputs at 224-199, A0-A24 controls at 182-158.
// - Data bits 31-0 use inputs 338-307, outputs 298-267, controls 266-235.
// - In boundary test, a control cell holding zero drives its pin from its output cell.
// - TMS/TDI are sampled on rising TCK, shift and TDO change on falling TCK.
// - Reset pin low enters the idle reset state without a link clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "jisc_consts.vh"
module jisc_scan_port (
    input wire mclk,
    input wire rst_b,
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire trst_b,
    output reg tdo,
    output reg tdo_oe,
    input wire [31:0] cpu_addr,
    input wire cpu_rd,
    input wire cpu_wr,
    output reg [15:0] cpu_rdata,
    output reg cpu_ack,
    input wire [31:0] d_pin_in,
    input wire [31:0] d_core_out,
    input wire [31:0] d_core_oe,
    output reg [31:0] d_pin_out,
    output reg [31:0] d_pin_oe,
    input wire [25:0] a_core_out,
    input wire [25:0] a_core_oe,
    output reg [25:0] a_pin_out,
    output reg [25:0] a_pin_oe,
    output reg debug_reset,
    output reg debug_irq,
    output reg wake_req,
    output wire cmd_valid,
    input wire cmd_ready,
    output wire [3:0] cmd_code
);
    localparam L = `JISC_BSC_LEN;

    // Instruction classes
    function is_chain;
        input [3:0] f;
        begin
            is_chain = (f == `JISC_OP_EXTEST) || (f == `JISC_OP_SAMPLE);
        end
    endfunction

    reg [3:0] sync1;
    reg [3:0] sync2;
    reg [31:0] dsync1;
    reg [31:0] d_in_s;
    reg tck_d;
    wire trst_s_b;
    wire tck_s;
    wire tms_s;
    wire tdi_s;
    wire tck_rise;
    wire tck_fall;
    wire in_tlr;
    wire cap_dr;
    wire sh_dr;
    wire up_dr;
    wire cap_ir;
    wire sh_ir;
    wire up_ir;

    reg [3:0] test_instruction_field;
    reg [15:0] ir_shift;
    reg bypass_cell;
    reg [L-1:0] pin_scan_chain;
    reg [L-1:0] chain_hold;
    reg [L-1:0] chain_cap;
    reg tdi_lat;
    reg shift_pend;
    reg cap_pend;
    reg pend_ir;
    reg push_pend;
    reg [3:0] push_code;
    wire push_ready;
    wire chain_sel;
    wire extest;
    integer i;

    assign {trst_s_b, tck_s, tms_s, tdi_s} = sync2;
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;
    assign chain_sel = is_chain(test_instruction_field);
    assign extest = (test_instruction_field == `JISC_OP_EXTEST);

    // Two-stage synchronisers for link pins and pad inputs
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            dsync1 <= 32'h00000000;
            d_in_s <= 32'h00000000;
            tck_d <= 1'b0;
        end else begin
            sync1 <= {trst_b, tck, tms, tdi};
            sync2 <= sync1;
            dsync1 <= d_pin_in;
            d_in_s <= dsync1;
            tck_d <= tck_s;
        end
    end

    jisc_tap_fsm u_tap (
        .mclk(mclk),
        .rst_b(rst_b),
        .trst_s_b(trst_s_b),
        .tck_rise(tck_rise),
        .tms_s(tms_s),
        .in_tlr(in_tlr),
        .cap_dr(cap_dr),
        .sh_dr(sh_dr),
        .up_dr(up_dr),
        .cap_ir(cap_ir),
        .sh_ir(sh_ir),
        .up_ir(up_ir)
    );

    // Capture image: pad inputs and the values now on the pads
    always @* begin
        chain_cap = chain_hold;
        for (i = 0; i < `JISC_D_W; i = i + 1) begin
            chain_cap[`JISC_D_IN_LSB + i] = d_in_s[i];
            chain_cap[`JISC_D_OUT_LSB + i] = d_pin_out[i];
            chain_cap[`JISC_D_CTL_LSB + i] = ~d_pin_oe[i];
        end
        for (i = 0; i < `JISC_A_W - 1; i = i + 1) begin
            chain_cap[`JISC_A_OUT_MSB - i] = a_pin_out[i];
            chain_cap[`JISC_A_CTL_MSB - i] = ~a_pin_oe[i];
        end
        chain_cap[`JISC_A_OUT_MSB - 25] = a_pin_out[25];
        chain_cap[`JISC_A25_CTL] = ~a_pin_oe[25];
    end

    // Serial engine: sample on rising link clock, act on falling
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tdi_lat <= 1'b0;
            shift_pend <= 1'b0;
            cap_pend <= 1'b0;
            pend_ir <= 1'b0;
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
            ir_shift <= `JISC_IR_RESET;
            bypass_cell <= 1'b0;
            pin_scan_chain <= {L{1'b1}};
        end else if (!trst_s_b) begin
            shift_pend <= 1'b0;
            cap_pend <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_rise) begin
            tdi_lat <= tdi_s;
            shift_pend <= sh_dr | sh_ir;
            cap_pend <= cap_dr | cap_ir;
            pend_ir <= sh_ir | cap_ir;
        end else if (tck_fall) begin
            tdo_oe <= sh_dr | sh_ir;
            shift_pend <= 1'b0;
            cap_pend <= 1'b0;
            if (cap_pend && pend_ir) begin
                ir_shift <= {test_instruction_field, 10'h3FF, `JISC_IR_CAPTURE_LOW};
                tdo <= 1'b1;
            end else if (cap_pend && chain_sel) begin
                pin_scan_chain <= chain_cap;
                tdo <= chain_cap[0];
            end else if (cap_pend) begin
                bypass_cell <= 1'b0;
                tdo <= 1'b0;
            end else if (shift_pend && pend_ir) begin
                ir_shift <= {tdi_lat, ir_shift[15:1]};
                tdo <= ir_shift[1];
            end else if (shift_pend && chain_sel) begin
                pin_scan_chain <= {tdi_lat, pin_scan_chain[L-1:1]};
                tdo <= pin_scan_chain[1];
            end else if (shift_pend) begin
                bypass_cell <= tdi_lat;
                tdo <= tdi_lat;
            end
        end
    end

    // Instruction holder, debug reset and command pulses
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            test_instruction_field <= `JISC_OP_BYPASS;
            debug_reset <= 1'b0;
            debug_irq <= 1'b0;
            wake_req <= 1'b0;
            chain_hold <= {L{1'b1}};
        end else begin
            debug_irq <= 1'b0;
            wake_req <= 1'b0;
            if (!trst_s_b || in_tlr) begin
                test_instruction_field <= `JISC_OP_BYPASS;
                debug_reset <= 1'b0;
            end else if (tck_fall && up_ir) begin
                test_instruction_field <= ir_shift[15:12];
                if (ir_shift[15:12] == `JISC_OP_DRST_ON) begin
                    debug_reset <= 1'b1;
                end else if (ir_shift[15:12] == `JISC_OP_DRST_OFF) begin
                    debug_reset <= 1'b0;
                end
                debug_irq <= (ir_shift[15:13] == `JISC_OP_IRQ_HI);
                wake_req <= (ir_shift[15:12] == `JISC_OP_WAKE);
            end else if (tck_fall && up_dr && chain_sel) begin
                chain_hold <= pin_scan_chain;
            end
        end
    end

    // Each loaded command is queued for the debug controller; a load while one waits on a full FIFO replaces it
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            push_pend <= 1'b0;
            push_code <= 4'h0;
        end else if (tck_fall && up_ir && trst_s_b && !in_tlr) begin
            push_pend <= 1'b1;
            push_code <= ir_shift[15:12];
        end else if (push_ready) begin
            push_pend <= 1'b0;
        end
    end

    jisc_fifo #(
        .W(`JISC_FLD_W),
        .D(`JISC_FIFO_DEPTH),
        .AW(`JISC_FIFO_AW)
    ) u_cmd_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(push_pend),
        .in_ready(push_ready),
        .in_data(push_code),
        .out_valid(cmd_valid),
        .out_ready(cmd_ready),
        .out_data(cmd_code)
    );

    // Pad drivers; control cells are active low in boundary test
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            d_pin_out <= 32'h00000000;
            d_pin_oe <= 32'h00000000;
            a_pin_out <= 26'h0000000;
            a_pin_oe <= 26'h0000000;
        end else begin
            for (i = 0; i < `JISC_D_W; i = i + 1) begin
                d_pin_out[i] <= extest ? chain_hold[`JISC_D_OUT_LSB + i] : d_core_out[i];
                d_pin_oe[i] <= extest ? ~chain_hold[`JISC_D_CTL_LSB + i] : d_core_oe[i];
            end
            for (i = 0; i < `JISC_A_W - 1; i = i + 1) begin
                a_pin_out[i] <= extest ? chain_hold[`JISC_A_OUT_MSB - i] : a_core_out[i];
                a_pin_oe[i] <= extest ? ~chain_hold[`JISC_A_CTL_MSB - i] : a_core_oe[i];
            end
            a_pin_out[25] <= extest ? chain_hold[`JISC_A_OUT_MSB - 25] : a_core_out[25];
            a_pin_oe[25] <= extest ? ~chain_hold[`JISC_A25_CTL] : a_core_oe[25];
        end
    end

    // CPU side: read-only instruction holder, writes acknowledged and dropped
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_rdata <= 16'h0000;
            cpu_ack <= 1'b0;
        end else begin
            cpu_ack <= cpu_rd | cpu_wr;
            if (cpu_rd && cpu_addr == `JISC_IR_ADDR) begin
                cpu_rdata <= {test_instruction_field, `JISC_IR_LOW_ONES};
            end else begin
                cpu_rdata <= 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

// [dv/jisc_scan_port_chk.sv]
// Port-level assertions for the scan port
`timescale 1ns/1ps
`default_nettype none
`include "jisc_consts.vh"
module jisc_scan_port_chk (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic trst_b,
    input wire logic tck,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [31:0] cpu_addr,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic [15:0] cpu_rdata,
    input wire logic cpu_ack,
    input wire logic debug_reset,
    input wire logic debug_irq,
    input wire logic wake_req,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [3:0] cmd_code,
    input wire logic [25:0] a_core_oe,
    input wire logic [25:0] a_pin_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire rd_ir = cpu_rd && cpu_addr == `JISC_IR_ADDR;
    a_ack_follows_req: assert property ((cpu_rd || cpu_wr) |=> cpu_ack)
        else $error("no ack after access");
    a_ack_has_cause: assert property (cpu_ack |-> $past(cpu_rd || cpu_wr))
        else $error("ack without access");
    a_read_low_ones: assert property (cpu_ack && $past(rd_ir) |->
        cpu_rdata[11:0] == `JISC_IR_LOW_ONES) else $error("low bits not ones");
    a_unmapped_zero: assert property ($past(cpu_rd && cpu_addr != `JISC_IR_ADDR) |->
        cpu_rdata == 16'h0000) else $error("unmapped read not zero");
    a_trst_ir_ones: assert property (!trst_b [*5] ##0 (cpu_ack && $past(rd_ir)) |->
        cpu_rdata == `JISC_IR_RESET) else $error("held reset read not all ones");
    a_trst_clears: assert property (!trst_b [*5] |-> !debug_reset && !tdo_oe)
        else $error("link reset did not clear");
    a_irq_single: assert property (debug_irq |=> !debug_irq)
        else $error("interrupt pulse too long");
    a_wake_single: assert property (wake_req |=> !wake_req)
        else $error("wake pulse too long");
    a_cmd_holds: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_code))
        else $error("command head lost");
    a_tdo_on_fall: assert property ($past(tdo_oe) && tdo_oe && $changed(tdo) |->
        !$past(tck, 2)) else $error("tdo moved outside low phase");
    a_pins_follow_core: assert property (!trst_b [*5] |-> a_pin_oe == $past(a_core_oe))
        else $error("pins not from core");
    c_irq: cover property (debug_irq);
    c_wake: cover property (wake_req);
    c_pop: cover property (cmd_valid && cmd_ready);
    c_drst: cover property ($rose(debug_reset));
endmodule
bind jisc_scan_port jisc_scan_port_chk chk (.mclk, .rst_b, .trst_b, .tck, .tdo, .tdo_oe,
    .cpu_addr, .cpu_rd, .cpu_wr, .cpu_rdata, .cpu_ack, .debug_reset, .debug_irq, .wake_req,
    .cmd_valid, .cmd_ready, .cmd_code, .a_core_oe, .a_pin_oe);
`default_nettype wire

// [dv/jisc_host_model.sv]
// Scan host model: drives the link pins and reads tdo
`timescale 1ns/1ps
`default_nettype none
module jisc_host_model (
    input wire logic mclk,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_b
);
    logic [338:0] got;
    initial begin
        tck = 0;
        tms = 1;
        tdi = 0;
        trst_b = 1;
    end
    // One link period of 8 mclk; tdo read late in the high phase
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        repeat (4) @(posedge mclk);
        #1 tck = 1;
        repeat (4) @(posedge mclk);
        o = tdo;
        #1 tck = 0;
    endtask
    // From idle through capture, n shift bits, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [338:0] din);
        logic o;
        step(1, ~tdi, o);
        if (ir) step(1, ~tdi, o);
        step(0, ~tdi, o);
        step(0, ~tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], got[i]);
        end
        step(1, ~tdi, o);
        step(0, ~tdi, o);
    endtask
    // Only listed codes are ever loaded
    task automatic load(input logic [3:0] f);
        scan(1, 16, {323'h0, f, 12'hABC});
    endtask
    task automatic to_idle();
        logic o;
        repeat (5) step(1, ~tdi, o);
        step(0, ~tdi, o);
    endtask
    task automatic link_reset();
        trst_b = 0;
        repeat (8) @(posedge mclk);
        #1 trst_b = 1;
    endtask
endmodule
`default_nettype wire

// [dv/jisc_scan_port_tb.sv]
// Self-checking bench for the scan port
`timescale 1ns/1ps
`default_nettype none
`include "jisc_consts.vh"
module jisc_scan_port_tb;
    logic mclk, rst_b, cpu_rd, cpu_wr, cmd_ready;
    logic [31:0] cpu_addr, d_pin_in, d_core_out, d_core_oe;
    logic [25:0] a_core_out, a_core_oe;
    wire tck, tms, tdi, trst_b, tdo, tdo_oe, cpu_ack, debug_reset, debug_irq, wake_req, cmd_valid;
    wire [15:0] cpu_rdata;
    wire [3:0] cmd_code;
    wire [31:0] d_pin_out, d_pin_oe;
    wire [25:0] a_pin_out, a_pin_oe;
    int bad_count, n_tests, irq_n, wake_n, oe_n;
    wire tdo_line;
    // Undriven serial line reads as the inverse of the last bit
    assign tdo_line = tdo_oe ? tdo : ~tdo;
    jisc_scan_port dut (.mclk, .rst_b, .tck, .tms, .tdi, .trst_b, .tdo, .tdo_oe, .cpu_addr,
        .cpu_rd, .cpu_wr, .cpu_rdata, .cpu_ack, .d_pin_in, .d_core_out, .d_core_oe, .d_pin_out,
        .d_pin_oe, .a_core_out, .a_core_oe, .a_pin_out, .a_pin_oe, .debug_reset, .debug_irq,
        .wake_req, .cmd_valid, .cmd_ready, .cmd_code);
    jisc_host_model host (.mclk, .tdo(tdo_line), .tck, .tms, .tdi, .trst_b);
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        irq_n += (debug_irq === 1'b1);
        wake_n += (wake_req === 1'b1);
        oe_n += (tdo_oe === 1'b1);
    end
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] e);
        cpu_addr = a;
        cpu_rd = !w;
        cpu_wr = w;
        @(posedge mclk);
        #1 cpu_rd = 0;
        cpu_wr = 0;
        chk(cpu_ack, 1);
        if (!w) chk(cpu_rdata, e);
        @(posedge mclk);
        #1;
    endtask
    function automatic logic [3:0] code_of(input int i);
        return (i % 3 == 0) ? 4'hF : (i % 3 == 1) ? 4'h4 : 4'h6;
    endfunction
    task automatic t_cpu();
        int oe0;
        bus(0, `JISC_IR_ADDR, 16'hFFFF);
        chk(tdo_oe, 0);
        bus(0, 32'h04000202, 16'h0000);
        bus(1, `JISC_IR_ADDR, 16'h0000);
        bus(0, `JISC_IR_ADDR, 16'hFFFF);
        oe0 = oe_n;
        host.scan(0, 8, {331'h0, 8'hA5});
        chk(host.got[7:0], 8'h4A);
        // Driven for 8 shift bits of 8 mclk each
        chk(oe_n - oe0, 64);
    endtask
    task automatic t_chain();
        logic [338:0] p;
        p = '1;
        d_pin_in = 32'h5AC3E187;
        p[298:267] = 32'h1234ABCD;
        p[266:235] = 32'hFFFF0000;
        for (int i = 0; i < 26; i++) begin
            p[224 - i] = i[0];
            p[(i == 25) ? 157 : 182 - i] = i[1];
        end
        host.load(4'h4);
        chk(host.got[1:0], 2'h1);
        chk(host.got[15:12], 4'hF);
        bus(0, `JISC_IR_ADDR, 16'h4FFF);
        host.scan(0, 339, p);
        chk(host.got[338:307], d_pin_in);
        d_core_out = 32'h0F0F1234;
        d_core_oe = 32'hF00F0FF0;
        a_core_out = 26'h2345678;
        a_core_oe = 26'h1F0E0D3;
        repeat (3) @(posedge mclk);
        #1 chk(d_pin_out, d_core_out);
        chk(d_pin_oe, 32'hF00F0FF0);
        chk(a_pin_out, 26'h2345678);
        chk(a_pin_oe, 26'h1F0E0D3);
        host.load(4'h0);
        chk(d_pin_out, 32'h1234ABCD);
        chk(d_pin_oe, 32'h0000FFFF);
        chk(a_pin_out, 26'h2AAAAAA);
        chk(a_pin_oe, 26'h3333333);
        host.load(4'hF);
        chk(d_pin_oe, d_core_oe);
    endtask
    task automatic t_cmds();
        int i0, w0;
        host.load(4'h7);
        chk(debug_reset, 1);
        host.load(4'hF);
        chk(debug_reset, 1);
        host.load(4'h6);
        chk(debug_reset, 0);
        i0 = irq_n;
        w0 = wake_n;
        host.load(4'hA);
        host.load(4'hB);
        host.load(4'h1);
        chk(irq_n - i0, 2);
        chk(wake_n - w0, 1);
        host.load(4'h7);
        host.to_idle();
        chk(debug_reset, 0);
        bus(0, `JISC_IR_ADDR, 16'hFFFF);
        host.load(4'h7);
        fork
            host.link_reset();
            begin
                repeat (5) @(posedge mclk);
                #1 bus(0, `JISC_IR_ADDR, 16'hFFFF);
            end
        join
        chk(debug_reset, 0);
        host.to_idle();
    endtask
    task automatic t_fifo();
        cmd_ready = 0;
        for (int i = 0; i < 34; i++) host.load(code_of(i));
        for (int i = 0; i < 33; i++) begin
            chk(cmd_valid, 1);
            chk(cmd_code, code_of(i < 32 ? i : 33));
            cmd_ready = 1;
            @(posedge mclk);
            #1 cmd_ready = 0;
            repeat (2) @(posedge mclk);
            #1;
        end
        chk(cmd_valid, 0);
        cmd_ready = 1;
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #1600000;
        bad_count++;
        final_report();
    end
    initial begin
        mclk = 0;
        rst_b = 0;
        cpu_rd = 0;
        cpu_wr = 0;
        cpu_addr = 32'h0;
        cmd_ready = 1;
        d_pin_in = 32'hC3A50F96;
        d_core_out = 32'h5A5A5A5A;
        d_core_oe = 32'h00FF00FF;
        a_core_out = 26'h1555555;
        a_core_oe = 26'h0F0F0F0;
        repeat (2) @(posedge mclk);
        #1 rst_b = 1;
        repeat (6) @(posedge mclk);
        #1 host.to_idle();
        t_cpu();
        t_chain();
        t_cmds();
        t_fifo();
        final_report();
    end
endmodule
`default_nettype wire
